// File: inc/timer_ctrl_params.svh
// offsets, bank number, field positions and reset values for the eight-bit counter control block
`ifndef TIMER_CTRL_PARAMS_SVH
`define TIMER_CTRL_PARAMS_SVH
`define CTRL_REG_OFFSET     8'h00
`define SHARED_REG_OFFSET   8'h01
`define BANK_OF_COUNTERS    4'hD
`define BIT_ENABLE          7
`define BIT_SINGLE          6
`define BIT_TIMEOUT         5
`define BIT_CLK_HI          4
`define BIT_CLK_LO          3
`define BIT_CAP_MASK        2
`define BIT_CNT_MASK        1
`define BIT_PIN_ROUTE       0
`define CTRL_RESET          8'h00
`define SHARED_RESET        8'h00
`define COUNT_RESET         8'h00
`define RP_RESET            8'h00
`define PRESCALE_RESET      3'h0
`endif

// File: inc/timer_ctrl_pkg.sv
// types for the eight-bit counter control block
package timer_ctrl_pkg;
    typedef enum logic [1:0] {
        CNT_IDLE = 2'b00,
        CNT_RUN  = 2'b01,
        CNT_DONE = 2'b11
    } cnt_state_e;
    typedef logic [1:0] clk_sel_t;
endpackage : timer_ctrl_pkg

// File: verilog/count_prescaler.sv
// count clock prescaler: one tick per 1, 2, 4 or 8 system clocks
`timescale 1ns/100ps
`default_nettype none
`include "timer_ctrl_params.svh"
module count_prescaler (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      run,
    input  wire timer_ctrl_pkg::clk_sel_t  sel,
    output logic                           tick
);
    logic [2:0] div;
    logic [2:0] mask;

    // select which divider bits must all be set for a tick
    assign mask = (sel == 2'b00) ? 3'h0 : (sel == 2'b01) ? 3'h1 : (sel == 2'b10) ? 3'h3 : 3'h7;
    assign tick = run && ((div & mask) == mask);

    // free running divider; the first tick after enable may land early
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div <= `PRESCALE_RESET;
        end else begin
            div <= div + 3'h1;
        end
    end
endmodule : count_prescaler
`default_nettype wire

// File: verilog/eight_bit_timer_control.sv
// control and status logic of the eight-bit down-counter
//
// Summary of operation
// - writing enable 1 starts counter, reads running
// - reload select 0 reloads at terminal count
// - reload select 1 stops at terminal count
// - terminal count sets timeout flag
// - timeout clears only by writing 1
// - first count period may be short
// - clock field selects count clock rate
// - capture mask gates capture interrupt
// - counter mask gates timeout interrupt
// - route bit selects port data or counter
// - pointer nibbles select group and bank
`timescale 1ns/100ps
`default_nettype none
`include "timer_ctrl_params.svh"
module eight_bit_timer_control (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  register_pointer,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic [7:0]  initial_count,
    input  wire logic        capture_event,
    input  wire logic        port_data,
    output logic             port_pin_four,
    output logic      [3:0]  working_group,
    output logic             timeout_irq,
    output logic             capture_irq,
    output logic      [7:0]  eight_bit_counter
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    // asynchronous assert, synchronous release
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic [7:0]                 ctrl;
    logic [7:0]                 shared;
    logic                       timeout;
    logic                       counter_out;
    timer_ctrl_pkg::cnt_state_e state;
    timer_ctrl_pkg::cnt_state_e next_state;
    logic                       tick;
    logic                       terminal;
    logic                       bank_hit;
    logic                       wr_ctrl;
    logic                       wr_shared;
    logic                       rd_ctrl;
    logic                       rd_shared;
    logic                       clear_timeout;
    logic                       start;
    logic                       stop;
    logic                       running;

    // counter registers only answer while the pointer selects their bank
    assign working_group = register_pointer[7:4];
    assign bank_hit      = register_pointer[3:0] == `BANK_OF_COUNTERS;
    assign wr_ctrl       = reg_wr && bank_hit && reg_addr == `CTRL_REG_OFFSET;
    assign wr_shared     = reg_wr && bank_hit && reg_addr == `SHARED_REG_OFFSET;
    assign rd_ctrl       = reg_rd && bank_hit && reg_addr == `CTRL_REG_OFFSET;
    assign rd_shared     = reg_rd && bank_hit && reg_addr == `SHARED_REG_OFFSET;
    assign clear_timeout = wr_ctrl && reg_wdata[`BIT_TIMEOUT];
    assign start         = wr_ctrl && reg_wdata[`BIT_ENABLE];
    assign stop          = wr_ctrl && !reg_wdata[`BIT_ENABLE];
    assign running       = state == timer_ctrl_pkg::CNT_RUN;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // whole written byte is stored; enable and timeout read back from state and flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl   <= `CTRL_RESET;
            shared <= `SHARED_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= reg_wdata;
            end
            if (wr_shared) begin
                shared <= reg_wdata;
            end
        end
    end

    // set beats clear so a timeout in the clearing cycle survives
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timeout <= 1'b0;
        end else if (terminal) begin
            timeout <= 1'b1;
        end else if (clear_timeout) begin
            timeout <= 1'b0;
        end
    end

    // read data is registered; bank mismatch reads zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (rd_ctrl) begin
            reg_rdata <= {running, ctrl[6], timeout, ctrl[4:0]};
        end else if (rd_shared) begin
            reg_rdata <= shared;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    count_prescaler u_prescaler (
        .clk   (clk),
        .rst_n (rst_n),
        .run   (running),
        .sel   (ctrl[`BIT_CLK_HI:`BIT_CLK_LO]),
        .tick  (tick)
    );

    assign terminal = running && tick && eight_bit_counter == 8'h01;

    // state: idle until enabled, done after a single pass
    always_comb begin
        next_state = state;
        case (state)
            timer_ctrl_pkg::CNT_IDLE: begin
                if (start) next_state = timer_ctrl_pkg::CNT_RUN;
            end
            timer_ctrl_pkg::CNT_RUN: begin
                if (stop) next_state = timer_ctrl_pkg::CNT_IDLE;
                else if (terminal && ctrl[`BIT_SINGLE]) next_state = timer_ctrl_pkg::CNT_DONE;
            end
            timer_ctrl_pkg::CNT_DONE: begin
                if (start) next_state = timer_ctrl_pkg::CNT_RUN;
                else if (stop) next_state = timer_ctrl_pkg::CNT_IDLE;
            end
            default: next_state = timer_ctrl_pkg::CNT_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= timer_ctrl_pkg::CNT_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // load on start and on reload, else count down on each tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eight_bit_counter <= `COUNT_RESET;
            counter_out       <= 1'b0;
        end else if (start && !running) begin
            eight_bit_counter <= initial_count;
            counter_out       <= 1'b0;
        end else if (terminal) begin
            eight_bit_counter <= ctrl[`BIT_SINGLE] ? 8'h00 : initial_count;
            counter_out       <= ~counter_out;
        end else if (running && tick) begin
            eight_bit_counter <= eight_bit_counter - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // timeout irq is level from the sticky flag, capture irq passes the event; no separate store
    assign timeout_irq   = timeout && ctrl[`BIT_CNT_MASK];
    assign capture_irq   = capture_event && ctrl[`BIT_CAP_MASK];
    assign port_pin_four = ctrl[`BIT_PIN_ROUTE] ? counter_out : port_data;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_timeout_sets: assert property (@(posedge clk) disable iff (!rst_n)
        terminal |=> timeout) else $error("timeout not set at terminal count");
    a_timeout_holds: assert property (@(posedge clk) disable iff (!rst_n)
        timeout && !clear_timeout |=> timeout) else $error("timeout lost without clear");
    a_zero_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ctrl && !reg_wdata[`BIT_TIMEOUT] && timeout |=> timeout) else $error("write 0 cleared");
    a_clear_works: assert property (@(posedge clk) disable iff (!rst_n)
        clear_timeout && !terminal |=> !timeout) else $error("timeout not cleared");
    a_start_runs: assert property (@(posedge clk) disable iff (!rst_n)
        start |=> running) else $error("enable did not start counter");
    a_single_stops: assert property (@(posedge clk) disable iff (!rst_n)
        terminal && ctrl[`BIT_SINGLE] && !wr_ctrl |=> !running) else $error("single pass kept running");
    a_modulo_reload: assert property (@(posedge clk) disable iff (!rst_n)
        terminal && !ctrl[`BIT_SINGLE] && !wr_ctrl |=> running && eight_bit_counter == $past(initial_count))
        else $error("no reload");
    a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
        terminal && ctrl[`BIT_CNT_MASK] && !wr_ctrl |=> timeout_irq) else $error("timeout irq not raised");
    a_pin_toggle: assert property (@(posedge clk) disable iff (!rst_n)
        terminal && ctrl[`BIT_PIN_ROUTE] && !wr_ctrl |=> port_pin_four != $past(port_pin_four))
        else $error("routed pin did not toggle");
    a_route_pin: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl[`BIT_PIN_ROUTE] |-> port_pin_four == port_data) else $error("pin route wrong");
    c_modulo: cover property (@(posedge clk) terminal && !ctrl[`BIT_SINGLE]);
    c_single: cover property (@(posedge clk) terminal && ctrl[`BIT_SINGLE]);
    c_set_clear: cover property (@(posedge clk) terminal && clear_timeout);
endmodule : eight_bit_timer_control
`default_nettype wire

// File: verification/tb_eight_bit_timer_control.sv
// self-checking bench for the eight-bit counter control block
`timescale 1ns/100ps
`default_nettype none
`include "timer_ctrl_params.svh"
module tb_eight_bit_timer_control;
    logic       clk, rstn, reg_wr, reg_rd, capture_event, port_data;
    logic [7:0] register_pointer, reg_addr, reg_wdata, initial_count;
    wire  [7:0] reg_rdata, eight_bit_counter;
    wire  [3:0] working_group;
    wire        port_pin_four, timeout_irq, capture_irq;
    int         errors = 0;
    int         n_compared = 0;
    int         cycles = 0;
    int unsigned seed = 2326;
    logic [7:0] d, v, g, n, prev;
    logic [1:0] dv;
    logic       m;
    int         k;
    int         t[3];
    logic       p[3];

    eight_bit_timer_control eight_bit_timer_control_inst (.clk(clk), .rstn(rstn),
        .register_pointer(register_pointer), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .initial_count(initial_count),
        .capture_event(capture_event), .port_data(port_data), .port_pin_four(port_pin_four),
        .working_group(working_group), .timeout_irq(timeout_irq), .capture_irq(capture_irq),
        .eight_bit_counter(eight_bit_counter));

    // --------------------------------------------------------------
    // helpers: stimulus source, bus cycles, compare, verdict
    // --------------------------------------------------------------
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one-cycle strobes, launched and dropped on falling edges
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = x;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] x);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        x = reg_rdata;
    endtask : rd

    task automatic finish_test();
        if (errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // hang guard: the whole run needs under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        {rstn, reg_wr, reg_rd, capture_event, port_data} = 5'b0_0000;
        {register_pointer, reg_addr, reg_wdata, initial_count} = 32'h0000_0000;
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        register_pointer = {4'h0, `BANK_OF_COUNTERS};
        rd(`CTRL_REG_OFFSET, d);
        check("ctrl reset", `CTRL_RESET, d);
        rd(`SHARED_REG_OFFSET, d);
        check("shared reset", `SHARED_RESET, d);
        port_data = 1'b1;
        #1 check("pin port data", 8'h01, {7'h00, port_pin_four});
        // bank decode, group output, unmapped offset
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            g = rnd();
            register_pointer = {g[3:0], `BANK_OF_COUNTERS};
            wr(`SHARED_REG_OFFSET, v);
            check("group", {4'h0, g[3:0]}, {4'h0, working_group});
            register_pointer = {g[3:0], 4'h3};
            wr(`SHARED_REG_OFFSET, ~v);
            rd(`SHARED_REG_OFFSET, d);
            check("other bank", 8'h00, d);
            register_pointer = {g[3:0], `BANK_OF_COUNTERS};
            rd(`SHARED_REG_OFFSET, d);
            check("shared", v, d);
            rd(8'h02, d);
            check("unmapped", 8'h00, d);
        end
        // capture interrupt gated by its mask
        for (int i = 0; i < 2; i++) begin
            wr(`CTRL_REG_OFFSET, {5'h00, i[0], 2'b00});
            @(negedge clk);
            capture_event = 1'b1;
            #1 check("capture irq", {7'h00, i[0]}, {7'h00, capture_irq});
            @(negedge clk);
            capture_event = 1'b0;
        end
        // single pass at every clock rate, timeout mask alternating
        wr(`CTRL_REG_OFFSET, 8'h20);
        for (int i = 0; i < 4; i++) begin
            dv = i[1:0];
            m = dv[0];
            n = 8'h04 + (rnd() & 8'h07);
            initial_count = n;
            wr(`CTRL_REG_OFFSET, {3'b110, dv, 1'b0, m, 1'b0});
            check("loaded", n, eight_bit_counter);
            rd(`CTRL_REG_OFFSET, d);
            check("running", {3'b110, dv, 1'b0, m, 1'b0}, d);
            for (int c = 0; c < 200 && eight_bit_counter !== 8'h00; c++)
                @(negedge clk);
            check("count end", 8'h00, eight_bit_counter);
            rd(`CTRL_REG_OFFSET, d);
            check("stopped", {3'b011, dv, 1'b0, m, 1'b0}, d);
            check("timeout irq", {7'h00, m}, {7'h00, timeout_irq});
            // write the flag bit as 0, never a read-back 1
            wr(`CTRL_REG_OFFSET, {3'b010, dv, 1'b0, m, 1'b0});
            rd(`CTRL_REG_OFFSET, d);
            check("flag kept", {3'b011, dv, 1'b0, m, 1'b0}, d);
            wr(`CTRL_REG_OFFSET, {3'b011, dv, 1'b0, m, 1'b0});
            rd(`CTRL_REG_OFFSET, d);
            check("flag cleared", {3'b010, dv, 1'b0, m, 1'b0}, d);
        end
        // auto reload: period and pin toggling at each clock rate
        for (int i = 0; i < 4; i++) begin
            dv = i[1:0];
            n = 8'h03 + (rnd() % 8'h05);
            initial_count = n;
            wr(`CTRL_REG_OFFSET, {3'b100, dv, 3'b001});
            prev = eight_bit_counter;
            t = '{0, 0, 0};
            k = 0;
            for (int c = 0; c < 400 && k < 3; c++) begin
                @(negedge clk);
                if (eight_bit_counter === n && prev !== n) begin
                    t[k] = c;
                    p[k] = port_pin_four;
                    k++;
                end
                prev = eight_bit_counter;
            end
            check("reload period", 8'(n << dv), 8'(t[2] - t[1]));
            check("pin toggle", {7'h00, ~p[1]}, {7'h00, p[2]});
            rd(`CTRL_REG_OFFSET, d);
            check("modulo run", {3'b101, dv, 3'b001}, d);
            wr(`CTRL_REG_OFFSET, {3'b000, dv, 3'b001});
            wr(`CTRL_REG_OFFSET, {3'b001, dv, 3'b001});
            rd(`CTRL_REG_OFFSET, d);
            check("stop clear", {3'b000, dv, 3'b001}, d);
        end
        finish_test();
    end
endmodule : tb_eight_bit_timer_control
`default_nettype wire
